/* File: hw/fwss_i2c_slave.v */
// Serial bus write/read slave with auto-incrementing byte address
`timescale 1ns/1ps
`include "fwss_defines.vh"
module fwss_i2c_slave #(
  parameter [6:0] DEV_ADDR = `FWSS_I2C_ADDR
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Synchronised bus levels
  input  wire       scl,
  input  wire       sda,
  output reg        sda_oe_q,
  // Byte access
  output reg        wr_stb_q,
  output reg  [7:0] wr_addr_q,
  output reg  [7:0] wr_data_q,
  output wire [7:0] rd_addr,
  input  wire [7:0] rd_data
);
  localparam ST_IDLE = 3'd0;
  localparam ST_DEV  = 3'd1;
  localparam ST_MA   = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_RD   = 3'd4;
  localparam ST_RACK = 3'd5;

  reg       scl_q;
  reg       sda_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;
  reg       ack_q;
  reg       ack_pend_q;
  reg [7:0] tx_q;

  wire rise  = scl & ~scl_q;
  wire fall  = ~scl & scl_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop  = scl & scl_q & ~sda_q & sda;
  wire [7:0] sh_next = {sh_q[6:0], sda};

  assign rd_addr = ptr_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      st_q       <= ST_IDLE;
      bit_q      <= 4'd0;
      sh_q       <= 8'h00;
      ptr_q      <= 8'h00;
      ack_q      <= 1'b0;
      ack_pend_q <= 1'b0;
      tx_q       <= 8'h00;
      sda_oe_q   <= 1'b0;
      wr_stb_q   <= 1'b0;
      wr_addr_q  <= 8'h00;
      wr_data_q  <= 8'h00;
    end else begin
      scl_q    <= scl;
      sda_q    <= sda;
      wr_stb_q <= 1'b0;
      if (start) begin
        st_q     <= ST_DEV;
        bit_q    <= 4'd0;
        ack_q    <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop) begin
        st_q     <= ST_IDLE;
        ack_q    <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (st_q != ST_IDLE) begin
        if (rise && !ack_q) begin
          if (st_q == ST_RD || st_q == ST_RACK) begin
            if (bit_q == 4'd8) begin
              // Master acknowledge continues a sequential read
              st_q <= sda ? ST_IDLE : ST_RACK;
            end
          end else begin
            sh_q <= sh_next;
          end
          bit_q <= bit_q + 4'd1;
        end
        if (fall) begin
          if (ack_q) begin
            ack_q    <= 1'b0;
            sda_oe_q <= 1'b0;
            bit_q    <= 4'd0;
            if (ack_pend_q) begin
              tx_q     <= rd_data;
              ptr_q    <= ptr_q + 8'd1;
              sda_oe_q <= ~rd_data[7];
            end
            ack_pend_q <= 1'b0;
          end else if (bit_q == 4'd8) begin
            case (st_q)
              ST_DEV: begin
                if (sh_q[7:1] == DEV_ADDR) begin
                  ack_q      <= 1'b1;
                  sda_oe_q   <= 1'b1;
                  st_q       <= sh_q[0] ? ST_RD : ST_MA;
                  ack_pend_q <= sh_q[0];
                end else begin
                  st_q <= ST_IDLE;
                end
              end
              ST_MA: begin
                ptr_q    <= sh_q;
                ack_q    <= 1'b1;
                sda_oe_q <= 1'b1;
                st_q     <= ST_DATA;
              end
              ST_DATA: begin
                // [RULE_15] Address advances per byte
                wr_stb_q  <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= sh_q;
                ptr_q     <= ptr_q + 8'd1;
                ack_q     <= 1'b1;
                sda_oe_q  <= 1'b1;
              end
              ST_RD: begin
                sda_oe_q <= 1'b0;
                st_q     <= ST_RACK;
              end
              default: begin
                sda_oe_q <= 1'b0;
              end
            endcase
          end else if (st_q == ST_RACK && bit_q == 4'd9) begin
            bit_q    <= 4'd0;
            tx_q     <= rd_data;
            ptr_q    <= ptr_q + 8'd1;
            sda_oe_q <= ~rd_data[7];
            st_q     <= ST_RD;
          end else if (st_q == ST_RD && bit_q < 4'd8) begin
            sda_oe_q <= ~tx_q[3'd7 - bit_q[2:0]];
          end
        end
      end
    end
  end
endmodule

/* File: hw/fwss_top.v */
// Frequency word store, selection and pin-one control
// Operation
// [RULE_01] Power-on copies four words to volatile
// [RULE_02] Serial changes volatile only, lost at reset
// [RULE_03] Four six-byte frequency words
// [RULE_04] Two-bit select byte picks active word
// [RULE_05] Select power-on value from programmed configuration
// [RULE_06] Serial writes may overwrite any word
// [RULE_07] Host rewrites only unselected words
// [RULE_08] Wait for relock after frequency change
// [RULE_09] Select pins choose word, msb upper
// [RULE_10] Pin one is gate or sleep
// [RULE_11] Gate disables output, PLL keeps running
// [RULE_12] Sleep stops clock, resumes after relock
// [RULE_13] Select byte at serial address 40h
// [RULE_14] Host writes upper select bits zero
// [RULE_15] Serial address advances after each byte
// [RULE_16] Select applies only after full byte
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`include "fwss_defines.vh"
module fwss_top #(
  parameter        LOCK_CYCLES = `FWSS_LOCK_CYCLES,
  parameter [6:0]  DEV_ADDR    = `FWSS_I2C_ADDR
) (
  // Clock and reset
  input  wire        SYS_CLK,
  input  wire        RST,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // Serial bus
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE,
  // Frequency select pins
  input  wire        FREQ_PICK_MSB,
  input  wire        FREQ_PICK_LSB,
  // Pin-one control
  input  wire        PIN_ONE,
  // PLL side
  output reg  [47:0] PLL_WORD,
  output reg  [1:0]  ACTIVE_SEL,
  output reg         PLL_RELOCK,
  output reg         PLL_POWER_ON,
  output reg         CLK_OUT_EN,
  output reg         LOAD_DONE
);
  localparam LD_COPY = 2'd0;
  localparam LD_RUN  = 2'd1;

  // Non-volatile image and volatile working copy
  reg [7:0]  nv_mem [0:24];
  reg [7:0]  vol_mem [0:23];
  reg [1:0]  vol_sel_q;
  reg [1:0]  ld_st_q;
  reg [4:0]  ld_idx_q;
  reg [31:0] ctrl_q;
  reg [4:0]  nv_index_q;
  reg [1:0]  pin_q1;
  reg [1:0]  pin_q2;
  reg        one_q1;
  reg        one_q2;
  reg        scl_q1;
  reg        scl_q2;
  reg        sda_q1;
  reg        sda_q2;
  reg [31:0] lock_cnt_q;
  reg [1:0]  last_sel_q;
  reg        asleep_q;
  integer    i;

  wire       sl_stb;
  wire [7:0] sl_addr;
  wire [7:0] sl_data;
  wire [7:0] sl_rd_addr;
  reg  [7:0] sl_rd_data;
  wire       sda_drive;

  function [4:0] byte_index;
    input [7:0] a;
    reg   [7:0] d;
    begin
      d = a - `FWSS_SERIAL_WORD0;
      byte_index = d[4:0];
    end
  endfunction

  function in_words;
    input [7:0] a;
    begin
      in_words = (a >= `FWSS_SERIAL_WORD0) && (a <= `FWSS_SERIAL_LAST);
    end
  endfunction

  // [RULE_03] Six bytes per word
  // Five-bit sum: word 3 starts at 18, past a four-bit index
  function [4:0] word_byte;
    input [1:0] k;
    input [2:0] n;
    begin
      word_byte = {1'b0, k, 2'b00} + {2'b00, k, 1'b0} + {2'b00, n};
    end
  endfunction

  wire apb_wr = PSEL & PENABLE & PWRITE;
  wire pin_mode = ctrl_q[`FWSS_CTRL_PIN_MODE];
  wire pin_variant = ctrl_q[`FWSS_CTRL_VARIANT];
  wire [1:0] pick = pin_variant ? pin_q2 : vol_sel_q;
  wire sleeping = pin_mode & ~one_q2;

  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = sda_drive;

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pin_q1 <= 2'b00;
      pin_q2 <= 2'b00;
      one_q1 <= 1'b0;
      one_q2 <= 1'b0;
      scl_q1 <= 1'b1;
      scl_q2 <= 1'b1;
      sda_q1 <= 1'b1;
      sda_q2 <= 1'b1;
    end else begin
      pin_q1 <= {FREQ_PICK_MSB, FREQ_PICK_LSB};
      pin_q2 <= pin_q1;
      one_q1 <= PIN_ONE;
      one_q2 <= one_q1;
      scl_q1 <= SCL_IN;
      scl_q2 <= scl_q1;
      sda_q1 <= SDA_IN;
      sda_q2 <= sda_q1;
    end
  end

  fwss_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .clk       (SYS_CLK),
    .rst       (RST),
    .scl       (scl_q2),
    .sda       (sda_q2),
    .sda_oe_q  (sda_drive),
    .wr_stb_q  (sl_stb),
    .wr_addr_q (sl_addr),
    .wr_data_q (sl_data),
    .rd_addr   (sl_rd_addr),
    .rd_data   (sl_rd_data)
  );

  always @* begin
    sl_rd_data = 8'h00;
    if (in_words(sl_rd_addr))
      sl_rd_data = vol_mem[byte_index(sl_rd_addr)];
    else if (sl_rd_addr == `FWSS_SERIAL_SELECT)
      sl_rd_data = {6'b00_0000, vol_sel_q};
  end

  // Non-volatile image, written only by the programming port
  always @(posedge SYS_CLK) begin
    if (apb_wr && PADDR == `FWSS_ADDR_NV_DATA && nv_index_q <= `FWSS_NV_SEL_INDEX)
      nv_mem[nv_index_q] <= PWDATA[7:0];
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q     <= `FWSS_CTRL_RESET;
      nv_index_q <= 5'h00;
    end else if (apb_wr) begin
      if (PADDR == `FWSS_ADDR_CTRL)
        ctrl_q <= PWDATA;
      else if (PADDR == `FWSS_ADDR_NV_INDEX)
        nv_index_q <= PWDATA[4:0];
      else if (PADDR == `FWSS_ADDR_NV_DATA)
        nv_index_q <= nv_index_q + 5'd1;
    end
  end

  always @* begin
    PRDATA = 32'h0000_0000;
    case (PADDR)
      `FWSS_ADDR_CTRL:     PRDATA = {30'h0000_0000, ctrl_q[1:0]};
      `FWSS_ADDR_STATUS:   PRDATA = {24'h00_0000, asleep_q, PLL_RELOCK, CLK_OUT_EN,
                                     LOAD_DONE, 2'b00, ACTIVE_SEL};
      `FWSS_ADDR_NV_INDEX: PRDATA = {27'h000_0000, nv_index_q};
      `FWSS_ADDR_NV_DATA:  PRDATA = {24'h00_0000, nv_mem[nv_index_q]};
      default:             PRDATA = 32'h0000_0000;
    endcase
  end

  // Volatile store: loaded from image after reset, then serial writes
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      // [RULE_02] Reset discards serial changes
      ld_st_q   <= LD_COPY;
      ld_idx_q  <= 5'd0;
      vol_sel_q <= 2'b00;
      LOAD_DONE <= 1'b0;
      for (i = 0; i < `FWSS_BYTE_COUNT; i = i + 1)
        vol_mem[i] <= 8'h00;
    end else begin
      case (ld_st_q)
        LD_COPY: begin
          // [RULE_01] Copy stored words
          if (ld_idx_q < `FWSS_BYTE_COUNT) begin
            vol_mem[ld_idx_q] <= nv_mem[ld_idx_q];
            ld_idx_q          <= ld_idx_q + 5'd1;
          end else begin
            // [RULE_05] Programmed power-on select
            vol_sel_q <= nv_mem[`FWSS_NV_SEL_INDEX][1:0];
            LOAD_DONE <= 1'b1;
            ld_st_q   <= LD_RUN;
          end
        end
        LD_RUN: begin
          if (sl_stb) begin
            // [RULE_06] Overwrite any word byte
            if (in_words(sl_addr))
              vol_mem[byte_index(sl_addr)] <= sl_data;
            // [RULE_13] Select byte decode
            else if (sl_addr == `FWSS_SERIAL_SELECT)
              // [RULE_16] Whole acknowledged byte only
              vol_sel_q <= sl_data[`FWSS_SEL_WORD_MSB:`FWSS_SEL_WORD_LSB];
          end
        end
        default: ld_st_q <= LD_RUN;
      endcase
    end
  end

  // PLL drive, gating and relock timing
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PLL_WORD     <= 48'h0000_0000_0000;
      ACTIVE_SEL   <= 2'b00;
      last_sel_q   <= 2'b00;
      lock_cnt_q   <= 32'h0000_0000;
      PLL_RELOCK   <= 1'b1;
      PLL_POWER_ON <= 1'b0;
      CLK_OUT_EN   <= 1'b0;
      asleep_q     <= 1'b0;
    end else begin
      // [RULE_04] Selected word drives PLL
      // [RULE_09] Pins select in pin variant
      ACTIVE_SEL <= pick;
      last_sel_q <= pick;
      // First byte of the word lands in the top byte
      PLL_WORD   <= {vol_mem[word_byte(pick, 3'd0)],
                     vol_mem[word_byte(pick, 3'd1)],
                     vol_mem[word_byte(pick, 3'd2)],
                     vol_mem[word_byte(pick, 3'd3)],
                     vol_mem[word_byte(pick, 3'd4)],
                     vol_mem[word_byte(pick, 3'd5)]};
      asleep_q     <= sleeping;
      PLL_POWER_ON <= LOAD_DONE & ~sleeping;
      // [RULE_08] Relock wait on change
      // [RULE_12] Sleep wake waits relock
      if (!LOAD_DONE || sleeping || pick != last_sel_q) begin
        lock_cnt_q <= LOCK_CYCLES;
        PLL_RELOCK <= 1'b1;
      end else if (lock_cnt_q != 32'h0000_0000) begin
        lock_cnt_q <= lock_cnt_q - 32'h0000_0001;
      end else begin
        PLL_RELOCK <= 1'b0;
      end
      // [RULE_10] One pin function
      // [RULE_11] Gate output only
      if (!pin_mode)
        CLK_OUT_EN <= LOAD_DONE & one_q2;
      else
        CLK_OUT_EN <= LOAD_DONE & ~sleeping & (lock_cnt_q == 32'h0000_0000) & ~PLL_RELOCK;
    end
  end
endmodule

/* File: include/fwss_defines.vh */
// Constants for the frequency word select store
`ifndef FWSS_DEFINES_VH
`define FWSS_DEFINES_VH
`define FWSS_WORD_COUNT      4
`define FWSS_WORD_BYTES      6
`define FWSS_BYTE_COUNT      24
`define FWSS_SERIAL_WORD0    8'h10
`define FWSS_SERIAL_LAST     8'h27
`define FWSS_SERIAL_SELECT   8'h40
`define FWSS_SEL_WORD_LSB    0
`define FWSS_SEL_WORD_MSB    1
`define FWSS_ADDR_CTRL       12'h000
`define FWSS_ADDR_STATUS     12'h004
`define FWSS_ADDR_NV_INDEX   12'h008
`define FWSS_ADDR_NV_DATA    12'h00C
`define FWSS_CTRL_RESET      32'h0000_0000
`define FWSS_CTRL_PIN_MODE   0
`define FWSS_CTRL_VARIANT    1
`define FWSS_NV_SEL_INDEX    5'h18
`define FWSS_LOCK_NS         100000
`define FWSS_CLK_NS          25
`define FWSS_LOCK_CYCLES     ((`FWSS_LOCK_NS + `FWSS_CLK_NS - 1) / `FWSS_CLK_NS)
`define FWSS_I2C_ADDR        7'h69
`endif

/* File: tb/fwss_checker.sv */
// Port property checks for the frequency word store
`timescale 1ns/1ps
module fwss_checker #(
  parameter LOCK_CYCLES = 20
) (
  // Clock and reset
  input wire       SYS_CLK,
  input wire       RST,
  // Bus and serial
  input wire       PSEL,
  input wire       PREADY,
  input wire       SDA_OUT,
  input wire       SDA_OE,
  // PLL side
  input wire [1:0] ACTIVE_SEL,
  input wire       PLL_RELOCK,
  input wire       PLL_POWER_ON,
  input wire       CLK_OUT_EN,
  input wire       LOAD_DONE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  reg [15:0] lock_q;
  reg [5:0]  up_q;
  // Relock length and time since reset
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      lock_q <= 16'h0000;
      up_q   <= 6'h00;
    end else begin
      lock_q <= (PLL_RELOCK && PLL_POWER_ON) ? lock_q + 16'h0001 : 16'h0000;
      up_q   <= (up_q == 6'h3F) ? up_q : up_q + 6'h01;
    end
  end
  AST_ZERO_WAIT: assert property (PSEL |-> PREADY)
    else $error("apb answer delayed");
  AST_SDA_DRAIN: assert property (SDA_OE |-> !SDA_OUT)
    else $error("sda driven high");
  AST_LOAD_TIME: assert property (up_q == 6'h20 |-> LOAD_DONE)
    else $error("load copy late");
  AST_LOAD_HOLD: assert property (LOAD_DONE |=> LOAD_DONE)
    else $error("load flag dropped");
  AST_SEL_RELOCK: assert property (
    LOAD_DONE && $past(LOAD_DONE) && $changed(ACTIVE_SEL) |-> ##[0:2] PLL_RELOCK)
    else $error("no relock on switch");
  AST_RELOCK_BOUND: assert property (lock_q <= LOCK_CYCLES + 6)
    else $error("relock too long");
  AST_SLEEP_DARK: assert property (!PLL_POWER_ON |-> !CLK_OUT_EN)
    else $error("output on while asleep");
  // Wake from sleep only; power-up after load is not a wake
  AST_WAKE_RELOCK: assert property (
    $rose(PLL_POWER_ON) && $past(LOAD_DONE, 2) |-> PLL_RELOCK && !CLK_OUT_EN)
    else $error("wake without relock");
  cover property (LOAD_DONE && $changed(ACTIVE_SEL));
  cover property (LOAD_DONE && $fell(PLL_POWER_ON));
  cover property (SDA_OE);
endmodule

bind fwss_top fwss_checker #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PREADY(PREADY),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ACTIVE_SEL(ACTIVE_SEL),
  .PLL_RELOCK(PLL_RELOCK), .PLL_POWER_ON(PLL_POWER_ON),
  .CLK_OUT_EN(CLK_OUT_EN), .LOAD_DONE(LOAD_DONE));

/* File: tb/fwss_i2c_host.sv */
// Serial bus host model, 200 ns bit period
`timescale 1ns/1ps
`include "fwss_defines.vh"
module fwss_i2c_host #(
  parameter [6:0] DEV_ADDR = `FWSS_I2C_ADDR
) (
  // Serial bus
  output logic scl,
  input  wire  sda_line,
  output logic sda_low
);
  int nacks;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nacks = 0;
  end
  task send(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~v[i];
      #50 scl = 1'b1;
      #100 scl = 1'b0;
      #50;
    end
    sda_low = 1'b0;
    #50 scl = 1'b1;
    #50 a = sda_line;
    #50 scl = 1'b0;
    #50;
    if (a !== 1'b0) nacks++;
  endtask
  // Start, address, pointer, n data bytes, stop
  task write(input logic [7:0] ma, input logic [7:0] b [6], input int n);
    // Keep bus edges off the system clock edges
    #7;
    sda_low = 1'b1;
    #50 scl = 1'b0;
    #50;
    send({DEV_ADDR, 1'b0});
    send(ma);
    for (int i = 0; i < n; i++) send(b[i]);
    sda_low = 1'b1;
    #50 scl = 1'b1;
    #50 sda_low = 1'b0;
    #100;
  endtask
endmodule

/* File: tb/fwss_top_tb.sv */
// Self-checking bench for the frequency word store
`timescale 1ns/1ps
module fwss_top_tb;
  reg          clk, rst, psel, penable, pwrite, pk1, pk0, pin;
  reg  [11:0]  paddr;
  reg  [31:0]  pwdata;
  wire [31:0]  prdata;
  wire [47:0]  word;
  wire [1:0]   sel;
  wire         pready, oe, so, scl, sdl, relock, pwr, en, done;
  wire         sda = ~(sdl | (oe & ~so));
  int          mismatches, total_checks;
  logic [7:0]  nv [24];
  logic [7:0]  d [6];
  logic [47:0] nw;
  logic [31:0] r;
  logic [1:0]  s0, w;
  fwss_top #(.LOCK_CYCLES(20)) dut (
    .SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(so), .SDA_OE(oe), .FREQ_PICK_MSB(pk1),
    .FREQ_PICK_LSB(pk0), .PIN_ONE(pin), .PLL_WORD(word), .ACTIVE_SEL(sel),
    .PLL_RELOCK(relock), .PLL_POWER_ON(pwr), .CLK_OUT_EN(en), .LOAD_DONE(done));
  fwss_i2c_host host (.scl(scl), .sda_line(sda), .sda_low(sdl));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    logic ok;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    ok = 1'b0;
    // Answer is read settled, ahead of the edge that completes it
    while (!ok) begin
      @(negedge clk);
      ok = (pready === 1'b1);
      r = prdata;
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task settle;
    repeat (6) @(posedge clk);
    while (relock !== 1'b0) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  task reboot;
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    while (done !== 1'b1) @(posedge clk);
    settle;
  endtask
  function logic [47:0] word_of(input logic [1:0] k);
    word_of = 48'h0000_0000_0000;
    for (int i = 0; i < 6; i++) word_of = {word_of[39:0], nv[k * 6 + i]};
  endfunction
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #2_000_000;
    mismatches++;
    finish_test;
  end
  initial begin
    {rst, pin} = 2'h3;
    {psel, penable, pwrite, pk1, pk0} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    r = $urandom(19298);
    reboot;
    apb(1'b1, 12'h008, 32'h0000_0000);
    for (int i = 0; i < 24; i++) begin
      nv[i] = $urandom;
      apb(1'b1, 12'h00C, {24'h00_0000, nv[i]});
    end
    s0 = $urandom;
    apb(1'b1, 12'h00C, {30'h0000_0000, s0});
    reboot;
    chk("start sel", s0, sel);
    chk("start word", word_of(s0), word);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("status sel", s0, r[1:0]);
    $display("load test done");
    w = s0 + 2'h1;
    for (int i = 0; i < 6; i++) d[i] = $urandom;
    nw = {d[0], d[1], d[2], d[3], d[4], d[5]};
    host.write(8'h10 + w * 6, d, 6);
    chk("word kept", word_of(s0), word);
    d[0] = {6'h00, w};
    host.write(8'h40, d, 1);
    @(posedge clk);
    chk("relock", 1'b1, relock);
    settle;
    chk("new sel", w, sel);
    chk("new word", nw, word);
    chk("nacks", 0, host.nacks);
    reboot;
    chk("cycled sel", s0, sel);
    chk("cycled word", word_of(s0), word);
    $display("serial test done");
    apb(1'b1, 12'h000, 32'h0000_0002);
    // Pin walk also shows the serially written word was restored
    for (int p = 0; p < 4; p++) begin
      {pk1, pk0} <= p[1:0];
      settle;
      chk("pin sel", p[1:0], sel);
      chk("pin word", word_of(p[1:0]), word);
    end
    apb(1'b1, 12'h000, 32'h0000_0000);
    settle;
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk("gated", 0, en);
    chk("gate power", 1, pwr);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ungated", 1, en);
    apb(1'b1, 12'h000, 32'h0000_0001);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk("sleep power", 0, pwr);
    chk("sleep out", 0, en);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk("wake early", 0, en);
    settle;
    chk("wake out", 1, en);
    apb(1'b0, 12'h010, 32'hFFFF_FFFF);
    chk("unmapped", 0, r);
    $display("pin test done");
    finish_test;
  end
endmodule
